//--- shared/vecm_consts.vh
// Constants for the vector-magnitude change detector
`ifndef VECM_CONSTS_VH
`define VECM_CONSTS_VH
// ****************************************
// Register offsets
// ****************************************
`define OFS_CONFIG      8'h5F
`define OFS_THS_HIGH    8'h60
`define OFS_THS_LOW     8'h61
`define OFS_DEB_COUNT   8'h62
`define OFS_REFX_HIGH   8'h63
`define OFS_REFX_LOW    8'h64
`define OFS_REFY_HIGH   8'h65
`define OFS_REFY_LOW    8'h66
`define OFS_REFZ_HIGH   8'h67
`define OFS_REFZ_LOW    8'h68
`define OFS_INT_SOURCE  8'h0C
`define OFS_IRQ_STATUS  8'h70
`define OFS_IRQ_MASK    8'h71
// ****************************************
// Field positions
// ****************************************
`define CFG_LATCH_BIT   6
`define CFG_INITM_BIT   5
`define CFG_UPDM_BIT    4
`define CFG_EN_BIT      3
`define THS_CLRM_BIT    7
`define SRC_VECM_BIT    1
`define STS_EVENT_BIT   0
`define STS_TRIG_BIT    1
// ****************************************
// Reset values
// ****************************************
`define RST_BYTE        8'h00
`endif

//--- core/vecm_distance.v
// Squared distance of a sample from a reference vector, one register stage
`timescale 1ns/10ps
module vecm_distance #(
  parameter W = 14
) (
  input  wire                clk_sys,
  input  wire                arst_n,
  input  wire signed [W-1:0] ax,
  input  wire signed [W-1:0] ay,
  input  wire signed [W-1:0] az,
  input  wire signed [W-1:0] rx,
  input  wire signed [W-1:0] ry,
  input  wire signed [W-1:0] rz,
  output reg  [2*W+2:0]      dist_sq_r
);
  wire signed [W:0] dx = {ax[W-1], ax} - {rx[W-1], rx};
  wire signed [W:0] dy = {ay[W-1], ay} - {ry[W-1], ry};
  wire signed [W:0] dz = {az[W-1], az} - {rz[W-1], rz};
  // Squares of W+1 signed bits fit 2W+1 unsigned; sum of three needs two more
  wire [2*W+1:0] sx = dx * dx;
  wire [2*W+1:0] sy = dy * dy;
  wire [2*W+1:0] sz = dz * dz;
  wire [2*W+2:0] sum = {1'b0, sx} + {1'b0, sy} + {1'b0, sz};

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dist_sq_r <= {(2*W+3){1'b0}};
    end else begin
      dist_sq_r <= sum;
    end
  end
endmodule // vecm_distance

//--- core/vecm_detect.v
// Accelerometer vector-magnitude change detector with register port
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`include "vecm_consts.vh"
module vecm_detect #(
  parameter W = 14
) (
  input  wire                clk_sys,
  input  wire                arst_n,
  input  wire [7:0]          reg_addr,
  input  wire [7:0]          reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [7:0]          reg_rdata_r,
  input  wire                sample_valid,
  input  wire                hybrid_mode,
  input  wire signed [W-1:0] accel_x,
  input  wire signed [W-1:0] accel_y,
  input  wire signed [W-1:0] accel_z,
  output reg                 event_flag_r,
  output reg                 irq_r
);
  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] cfg_r;
  reg [7:0] ths_high_r;
  reg [7:0] ths_low_r;
  reg [7:0] deb_count_r;
  reg [7:0] refx_high_r, refx_low_r;
  reg [7:0] refy_high_r, refy_low_r;
  reg [7:0] refz_high_r, refz_low_r;
  reg [1:0] irq_status_r;
  reg [1:0] irq_mask_r;

  wire latch_en  = cfg_r[`CFG_LATCH_BIT];
  wire init_sel  = cfg_r[`CFG_INITM_BIT];
  wire upd_hold  = cfg_r[`CFG_UPDM_BIT];
  wire det_en    = cfg_r[`CFG_EN_BIT];
  wire clr_mode  = ths_high_r[`THS_CLRM_BIT];
  // Threshold LSB is one output step, so comparison is in raw sample units
  wire [12:0] threshold = {ths_high_r[4:0], ths_low_r};

  wire signed [W-1:0] init_x = {refx_high_r[5:0], refx_low_r};
  wire signed [W-1:0] init_y = {refy_high_r[5:0], refy_low_r};
  wire signed [W-1:0] init_z = {refz_high_r[5:0], refz_low_r};

  wire wr_hit_ths = reg_wr && (reg_addr == `OFS_THS_HIGH);
  wire src_read   = reg_rd && (reg_addr == `OFS_INT_SOURCE);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r       <= `RST_BYTE;
      ths_high_r  <= `RST_BYTE;
      ths_low_r   <= `RST_BYTE;
      deb_count_r <= `RST_BYTE;
      refx_high_r <= `RST_BYTE;
      refx_low_r  <= `RST_BYTE;
      refy_high_r <= `RST_BYTE;
      refy_low_r  <= `RST_BYTE;
      refz_high_r <= `RST_BYTE;
      refz_low_r  <= `RST_BYTE;
      irq_mask_r  <= 2'b00;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_CONFIG:    cfg_r       <= reg_wdata;
        `OFS_THS_HIGH:  ths_high_r  <= reg_wdata;
        `OFS_THS_LOW:   ths_low_r   <= reg_wdata;
        `OFS_DEB_COUNT: deb_count_r <= reg_wdata;
        `OFS_REFX_HIGH: refx_high_r <= reg_wdata;
        `OFS_REFX_LOW:  refx_low_r  <= reg_wdata;
        `OFS_REFY_HIGH: refy_high_r <= reg_wdata;
        `OFS_REFY_LOW:  refy_low_r  <= reg_wdata;
        `OFS_REFZ_HIGH: refz_high_r <= reg_wdata;
        `OFS_REFZ_LOW:  refz_low_r  <= reg_wdata;
        `OFS_IRQ_MASK:  irq_mask_r  <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Sample rate divider
  // ****************************************
  // In hybrid mode only every second sample drives the debounce counter
  reg  sample_phase_r;
  wire tick = sample_valid && (!hybrid_mode || sample_phase_r);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sample_phase_r <= 1'b0;
    end else if (!hybrid_mode) begin
      sample_phase_r <= 1'b0;
    end else if (sample_valid) begin
      sample_phase_r <= ~sample_phase_r;
    end
  end

  // ****************************************
  // Reference vector
  // ****************************************
  reg signed [W-1:0] ref_x_r, ref_y_r, ref_z_r;
  reg                en_d_r;
  reg                trig_pulse_r;
  wire               en_rise = det_en && !en_d_r;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ref_x_r <= {W{1'b0}};
      ref_y_r <= {W{1'b0}};
      ref_z_r <= {W{1'b0}};
      en_d_r  <= 1'b0;
    end else begin
      en_d_r <= det_en;
      if (en_rise) begin
        if (init_sel) begin
          ref_x_r <= init_x;
          ref_y_r <= init_y;
          ref_z_r <= init_z;
        end else begin
          ref_x_r <= accel_x;
          ref_y_r <= accel_y;
          ref_z_r <= accel_z;
        end
      end else if (det_en && upd_hold && init_sel) begin
        // Host may steer the reference live through the initial registers
        ref_x_r <= init_x;
        ref_y_r <= init_y;
        ref_z_r <= init_z;
      end else if (det_en && !upd_hold && trig_pulse_r) begin
        ref_x_r <= accel_x;
        ref_y_r <= accel_y;
        ref_z_r <= accel_z;
      end
    end
  end

  // ****************************************
  // Distance and debounce
  // ****************************************
  wire [2*W+2:0] dist_sq;

  vecm_distance #(
    .W (W)
  ) u_distance (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .ax        (accel_x),
    .ay        (accel_y),
    .az        (accel_z),
    .rx        (ref_x_r),
    .ry        (ref_y_r),
    .rz        (ref_z_r),
    .dist_sq_r (dist_sq)
  );

  // Comparing squares avoids a square root; one-cycle lag of distance is negligible
  wire [25:0]    ths_sq = threshold * threshold;
  wire           above  = dist_sq > {{(2*W+3-26){1'b0}}, ths_sq};

  reg  [7:0] deb_cnt_r;
  reg        cond_r;
  wire       cnt_done = (deb_cnt_r >= deb_count_r);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      deb_cnt_r    <= 8'h00;
      cond_r       <= 1'b0;
      trig_pulse_r <= 1'b0;
    end else begin
      trig_pulse_r <= 1'b0;
      if (!det_en) begin
        deb_cnt_r <= 8'h00;
        cond_r    <= 1'b0;
      end else if (tick) begin
        if (above) begin
          // Longer than count: condition asserts on the sample after reaching it
          if (cnt_done) begin
            if (!cond_r) begin
              trig_pulse_r <= 1'b1;
            end
            cond_r <= 1'b1;
          end else begin
            deb_cnt_r <= deb_cnt_r + 8'h01;
          end
        end else if (clr_mode) begin
          deb_cnt_r <= 8'h00;
          cond_r    <= 1'b0;
        end else if (deb_cnt_r != 8'h00) begin
          deb_cnt_r <= deb_cnt_r - 8'h01;
        end else begin
          cond_r <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Event flag, interrupt, read port
  // ****************************************
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      event_flag_r <= 1'b0;
      irq_status_r <= 2'b00;
      irq_r        <= 1'b0;
      reg_rdata_r  <= 8'h00;
    end else begin
      if (!latch_en) begin
        event_flag_r <= cond_r;
      end else if (trig_pulse_r) begin
        event_flag_r <= 1'b1;
      end else if (src_read) begin
        event_flag_r <= 1'b0;
      end
      // Set wins over a same-cycle write-one clear
      irq_status_r[`STS_EVENT_BIT] <= (cond_r && !event_flag_r) ||
        (irq_status_r[`STS_EVENT_BIT] &&
         !(reg_wr && reg_addr == `OFS_IRQ_STATUS && reg_wdata[`STS_EVENT_BIT]));
      irq_status_r[`STS_TRIG_BIT] <= trig_pulse_r ||
        (irq_status_r[`STS_TRIG_BIT] &&
         !(reg_wr && reg_addr == `OFS_IRQ_STATUS && reg_wdata[`STS_TRIG_BIT]));
      irq_r <= |(irq_status_r & irq_mask_r);
      reg_rdata_r <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `OFS_CONFIG:     reg_rdata_r <= cfg_r;
          `OFS_THS_HIGH:   reg_rdata_r <= ths_high_r;
          `OFS_THS_LOW:    reg_rdata_r <= ths_low_r;
          `OFS_DEB_COUNT:  reg_rdata_r <= deb_count_r;
          `OFS_REFX_HIGH:  reg_rdata_r <= refx_high_r;
          `OFS_REFX_LOW:   reg_rdata_r <= refx_low_r;
          `OFS_REFY_HIGH:  reg_rdata_r <= refy_high_r;
          `OFS_REFY_LOW:   reg_rdata_r <= refy_low_r;
          `OFS_REFZ_HIGH:  reg_rdata_r <= refz_high_r;
          `OFS_REFZ_LOW:   reg_rdata_r <= refz_low_r;
          `OFS_INT_SOURCE: reg_rdata_r <= {6'b00_0000, event_flag_r, 1'b0};
          `OFS_IRQ_STATUS: reg_rdata_r <= {6'b00_0000, irq_status_r};
          `OFS_IRQ_MASK:   reg_rdata_r <= {6'b00_0000, irq_mask_r};
          default:         reg_rdata_r <= 8'h00;
        endcase
      end
    end
  end
endmodule // vecm_detect

//--- tb/vecm_detect_assertions.sv
// Checker for register port and flag timing of the detector
`timescale 1ns/10ps
module vecm_detect_assertions (
  input wire       clk_sys,
  input wire       arst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata_r,
  input wire       sample_valid,
  input wire       event_flag_r,
  input wire       irq_r
);
  wire rd_src = reg_rd && reg_addr == 8'h0C;
  wire wr_irq = reg_wr && reg_addr[7:1] == 7'h38;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata_r == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmapped; $past(reg_rd && reg_addr == 8'h50) |-> reg_rdata_r == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rb_ths; (reg_wr && reg_addr == 8'h60) ##1 (reg_rd && reg_addr == 8'h60)
    |=> reg_rdata_r == $past(reg_wdata, 2); endproperty
  a_rb_ths: assert property (p_rb_ths) else $error("threshold readback");
  property p_rb_cnt; (reg_wr && reg_addr == 8'h62) ##1 (reg_rd && reg_addr == 8'h62)
    |=> reg_rdata_r == $past(reg_wdata, 2); endproperty
  a_rb_cnt: assert property (p_rb_cnt) else $error("count readback");
  property p_rb_refx; (reg_wr && reg_addr == 8'h64) ##1 (reg_rd && reg_addr == 8'h64)
    |=> reg_rdata_r == $past(reg_wdata, 2); endproperty
  a_rb_refx: assert property (p_rb_refx) else $error("reference readback");
  // The flag may only rise on a sample tick and fall on one or a source read, so a free-running counter shows here
  property p_flag_rise; $rose(event_flag_r)
    |-> $past(sample_valid) || $past(sample_valid, 2) || $past(sample_valid, 3); endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag rose without tick");
  property p_flag_fall; $fell(event_flag_r) |-> $past(sample_valid) || $past(sample_valid, 2)
    || $past(sample_valid, 3) || $past(rd_src) || $past(rd_src, 2); endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("flag fell without cause");
  property p_irq_fall; $fell(irq_r) |-> $past(wr_irq) || $past(wr_irq, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without write");
endmodule // vecm_detect_assertions

//--- tb/accel_source.sv
// Sensor front end model: one sample every eight cycles
`timescale 1ns/10ps
module accel_source (
  input  wire               clk_sys,
  input  wire               arst_n,
  input  wire        [13:0] tgt_x,
  output reg                sample_valid,
  output reg  signed [13:0] accel_x,
  output reg  signed [13:0] accel_y,
  output reg  signed [13:0] accel_z
);
  reg [2:0] phase_r;
  // Data land two cycles ahead of the tick so the distance stage has settled
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase_r      <= 3'h0;
      sample_valid <= 1'b0;
      accel_x      <= 14'h0000;
      accel_y      <= 14'h0000;
      accel_z      <= 14'h0000;
    end else begin
      phase_r      <= phase_r + 3'h1;
      sample_valid <= phase_r == 3'h5;
      if (phase_r == 3'h3) begin
        accel_x <= tgt_x;
        accel_y <= 14'h0155;
        accel_z <= 14'h3F9C;
      end
    end
  end
endmodule // accel_source

//--- tb/vecm_detect_test.sv
// Self-checking bench for the vector-magnitude detector
`timescale 1ns/10ps
module vecm_detect_test;
  logic              clk_sys = 1'b0;
  logic              arst_n = 1'b0;
  logic [7:0]        reg_addr = 8'h00;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              hybrid_mode = 1'b0;
  logic [13:0]       tgt_x = 14'h3FF6;
  logic [7:0]        v;
  wire  [7:0]        reg_rdata_r;
  wire               sample_valid;
  wire               event_flag_r;
  wire               irq_r;
  wire signed [13:0] accel_x;
  wire signed [13:0] accel_y;
  wire signed [13:0] accel_z;
  int                errors = 0;
  int                tests_run = 0;
  // Address, write data, read-back; refs give distance 20 at x=0, 10 at x=-10
  logic [23:0] rows [10] = '{24'h6080_80, 24'h610A_0A, 24'h6202_02, 24'h633F_3F,
    24'h64EC_EC, 24'h6501_01, 24'h6655_55, 24'h673F_3F, 24'h689C_9C, 24'h50FF_00};
  always #5 clk_sys = ~clk_sys;
  vecm_detect #(.W(14)) vecm_detect_inst (.clk_sys, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata_r, .sample_valid, .hybrid_mode, .accel_x, .accel_y,
    .accel_z, .event_flag_r, .irq_r);
  accel_source accel_source_inst (.clk_sys, .arst_n, .tgt_x, .sample_valid, .accel_x,
    .accel_y, .accel_z);
  task automatic summarize;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, 1'b1, a, 8'h00);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata_r;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys iff sample_valid === 1'b1);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Move the sample, let n samples pass, then look at the flag
  task automatic step(input logic [13:0] x, input int n, input logic e, input string s);
    @(posedge clk_sys) tgt_x <= x;
    // A change that misses the model's copy slot must not count a tick of stale data
    wait (accel_x === x);
    ticks(n);
    chk8(s, {7'h00, e}, {7'h00, event_flag_r});
  endtask
  initial begin
    #100000;
    errors++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int a = 8'h5F; a < 8'h69; a++) begin
      rd(a[7:0]);
      chk8("reset value", 8'h00, v);
    end
    foreach (rows[i]) begin
      bus(1'b1, 1'b0, rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      chk8("readback", rows[i][7:0], v);
    end
    wr(8'h5F, 8'h38);
    step(14'h0000, 2, 1'b0, "flag early");
    step(14'h0000, 1, 1'b1, "flag set");
    step(14'h3FF6, 1, 1'b0, "flag clear mode");
    wr(8'h60, 8'h00);
    step(14'h0000, 3, 1'b1, "flag set again");
    step(14'h3FF6, 2, 1'b1, "flag decrement");
    step(14'h3FF6, 1, 1'b0, "flag drained");
    @(posedge clk_sys) hybrid_mode <= 1'b1;
    step(14'h0000, 4, 1'b0, "hybrid early");
    step(14'h0000, 2, 1'b1, "hybrid set");
    step(14'h3FF6, 6, 1'b0, "hybrid drained");
    @(posedge clk_sys) hybrid_mode <= 1'b0;
    chk8("irq masked", 8'h00, {7'h00, irq_r});
    wr(8'h71, 8'h01);
    ticks(0);
    chk8("irq raised", 8'h01, {7'h00, irq_r});
    wr(8'h70, 8'h03);
    ticks(0);
    chk8("irq cleared", 8'h00, {7'h00, irq_r});
    wr(8'h5F, 8'h78);
    step(14'h0000, 3, 1'b1, "latched set");
    step(14'h3FF6, 4, 1'b1, "latched held");
    rd(8'h0C);
    chk8("source", 8'h02, v & 8'h02);
    ticks(0);
    chk8("latched read", 8'h00, {7'h00, event_flag_r});
    wr(8'h5F, 8'h00);
    wr(8'h5F, 8'h08);
    wr(8'h61, 8'h05);
    step(14'h0000, 3, 1'b1, "live ref set");
    step(14'h0000, 3, 1'b0, "ref followed");
    @(posedge clk_sys) arst_n <= 1'b0;
    @(posedge clk_sys) arst_n <= 1'b1;
    rd(8'h62);
    chk8("second reset", 8'h00, v);
    summarize();
  end
endmodule // vecm_detect_test
bind vecm_detect vecm_detect_assertions vecm_detect_assertions_inst (.clk_sys, .arst_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .sample_valid, .event_flag_r, .irq_r);
